//--- core/ssx_pkg.sv
/*
  Constants, modes and state types of the two-wire slave port.
  Assumes nothing; shared by all design files except ssx_sync.
*/
package ssx_pkg;
  localparam logic [3:0] MODE_S7    = 4'h6;
  localparam logic [3:0] MODE_S10   = 4'h7;
  localparam logic [3:0] MODE_LDMSK = 4'h9;
  localparam logic [3:0] MODE_FWM   = 4'hB;
  localparam logic [3:0] MODE_S7I   = 4'hE;
  localparam logic [3:0] MODE_S10I  = 4'hF;
  localparam logic [4:0] TEN_HI_PAT = 5'h1E;
  localparam logic [7:0] MASK_RST   = 8'hFF;
  localparam logic [7:0] ADDR_RST   = 8'h00;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [3:0] RX_LAST    = 4'h8;
  localparam logic [3:0] TX_LAST    = 4'h7;
  localparam logic [3:0] CNT_RST    = 4'h0;
  localparam logic [3:0] CNT_ONE    = 4'h1;
  localparam logic       CKP_RST    = 1'h0;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RX   = 3'b001,
    S_ACK  = 3'b010,
    S_TX   = 3'b011,
    S_MACK = 3'b100
  } ssx_state_t;

  typedef enum logic [1:0] {
    PH_A1   = 2'b00,
    PH_A2   = 2'b01,
    PH_DATA = 2'b10,
    PH_SKIP = 2'b11
  } ssx_phase_t;
endpackage

//--- core/ssx_sync.sv
/*
  Two-flop synchroniser for one line.
  Assumes an active-low asynchronous reset already released cleanly.
*/
`timescale 1ns/1ps
`default_nettype none
module ssx_sync #(
  parameter logic RST_VAL = 1'h1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);
  logic meta_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

//--- core/ssx_addr_cmp.sv
/*
  Masked address comparator.
  Assumes all inputs are registered on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ssx_addr_cmp (
  input  wire logic [7:0] rx,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] mask,
  input  wire logic       use_lsb,
  output var  logic       match
);
  logic [7:0] sel;

  always_comb begin
    // Bit 0 only counts for the low byte of a long address
    sel   = {mask[7:1], mask[0] & use_lsb};
    match = ((rx ^ addr) & sel) == ssx_pkg::BYTE_RST;
  end
endmodule
`default_nettype wire

//--- core/ssx_slave.sv
/*
  Two-wire slave port: 7/10-bit addressing, masking, receive, transmit,
  clock stretching, start/stop detection. Assumes CPU-side strobes are
  one-cycle pulses on REF_CLK; bus lines come from pins with pull-ups.
*/
// Behaviour
// RL1: Long address first byte is 11110, A9, A8, then write bit.
// RL2: Each long address byte sets irq, buffer-full, update-address; clock held.
// RL3: Writing address register clears update-address and releases clock.
// RL4: Reading the buffer clears buffer-full.
// RL5: Repeated start plus high byte with read sets full, clears release, stretches.
// RL6: Mask reachable only in mode 1001, through the address location.
// RL7: Zero mask bits exclude that address bit from matching.
// RL8: Mask resets to all ones.
// RL9: Matched write address loads buffer; unread before next byte gives overflow.
// RL10: Every byte raises irq and updates full, direction, data/address status.
// RL11: Read address match sets direction, acknowledges, then stretches clock.
// RL12: Buffer write sets full; setting release bit frees the clock.
// RL13: Transmit clears full at 8th fall, raises irq at 9th fall.
// RL14: After 8th fall data released; nack ends, ack stretches for next byte.
// RL15: Software clears irq before the next byte is sent.
// RL16: Clock stretched after long address bytes and while release bit clear.
// RL17: Start/stop seen bits clear on reset or disable, else follow conditions.
// RL18: Firmware master takes bus only after stop or when fully idle.
// RL19: Firmware master drives lines only low through the direction bit.
// RL20: Mode 1011 or event modes raise irq on start, stop and bytes.
// RL21: Stop condition raises irq so firmware sees the bus free.
// RL22: Arbitration checks belong to firmware; slave still answers if addressed.
// RL23: Full or overflow at byte end: no load, no ack, irq still set.
// RL24: Modes 0110, 0111, 1110, 1111 select slave width and event irqs.
// RL25: Clock held only after seen low; freed once release bit set.
// RL26: Lines are synchronised and edge-detected before any use.
`timescale 1ns/1ps
`default_nettype none
module ssx_slave (
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  input  wire logic       SCL_DIR,
  input  wire logic       SDA_DIR,
  input  wire logic       PORT_EN,
  input  wire logic [3:0] MODE,
  input  wire logic       BUF_WR,
  input  wire logic [7:0] BUF_WDATA,
  input  wire logic       BUF_RD,
  input  wire logic       ADDR_WR,
  input  wire logic [7:0] ADDR_WDATA,
  input  wire logic       CKP_SET,
  input  wire logic       IRQ_CLR,
  input  wire logic       OV_CLR,
  output var  logic       SCL_O,
  output var  logic       SCL_OE_B,
  output var  logic       SDA_O,
  output var  logic       SDA_OE_B,
  output var  logic [7:0] BUF_RDATA,
  output var  logic [7:0] ADDR_RDATA,
  output var  logic       IRQ_FLAG,
  output var  logic       BUF_FULL,
  output var  logic       OVERFLOW,
  output var  logic       UPDATE_ADDR,
  output var  logic       CLK_RELEASE,
  output var  logic       DATA_NOT_ADDR,
  output var  logic       READ_DIR,
  output var  logic       START_SEEN,
  output var  logic       STOP_SEEN
);
  logic                 rst_meta_ff, rst_n_ff;
  logic                 scl_s, sda_s, scl_q_ff, sda_q_ff;
  logic                 scl_rise, scl_fall, start_det, stop_det;
  logic                 slave_on, ten, fwm, evt_mode, ld_mask;
  ssx_pkg::ssx_state_t  st_ff;
  ssx_pkg::ssx_phase_t  ph_ff, nxt_ph;
  logic [3:0]           cnt_ff;
  logic [7:0]           sr_ff, tx_ff, buf_ff, addr_ff, mask_ff;
  logic                 bf_ff, ov_ff, ua_ff, ckp_ff, irq_ff, da_ff, rw_ff, s_ff, p_ff;
  logic                 ack_ff, nack_ff, hit10_ff, hold_ff, mask_touched_ff, pin_lo_ff;
  logic                 m7, m10lo, hi_ok, room, byte_end, load;
  logic                 hit, go_rd, set_ua, hit10_set, is_data, nxt_hold, sda_drv;

  // Reset release through two flops
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_ff <= 1'h0;
      rst_n_ff    <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  ssx_sync #(.RST_VAL(1'h1)) u_scl_sync (.clk(REF_CLK), .rst_n(rst_n_ff), .d(SCL_I), .q(scl_s)); // RL26
  ssx_sync #(.RST_VAL(1'h1)) u_sda_sync (.clk(REF_CLK), .rst_n(rst_n_ff), .d(SDA_I), .q(sda_s)); // RL26

  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      scl_q_ff <= 1'h1;
      sda_q_ff <= 1'h1;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  ssx_addr_cmp u_cmp7  (.rx(sr_ff), .addr(addr_ff), .mask(mask_ff), .use_lsb(1'h0), .match(m7));    // RL7
  ssx_addr_cmp u_cmp10 (.rx(sr_ff), .addr(addr_ff), .mask(mask_ff), .use_lsb(1'h1), .match(m10lo)); // RL7

  always_comb begin
    scl_rise  = scl_s & ~scl_q_ff;                                   // RL26
    scl_fall  = ~scl_s & scl_q_ff;                                   // RL26
    start_det = scl_s & scl_q_ff & ~sda_s & sda_q_ff;
    stop_det  = scl_s & scl_q_ff & sda_s & ~sda_q_ff;
    ten       = (MODE == ssx_pkg::MODE_S10) | (MODE == ssx_pkg::MODE_S10I); // RL24
    slave_on  = PORT_EN & (ten | (MODE == ssx_pkg::MODE_S7) | (MODE == ssx_pkg::MODE_S7I)); // RL24
    fwm       = PORT_EN & (MODE == ssx_pkg::MODE_FWM);
    evt_mode  = fwm | (MODE == ssx_pkg::MODE_S7I) | (MODE == ssx_pkg::MODE_S10I); // RL20
    ld_mask   = MODE == ssx_pkg::MODE_LDMSK;
    hi_ok     = (sr_ff[7:3] == ssx_pkg::TEN_HI_PAT) & (sr_ff[2:1] == addr_ff[2:1]); // RL1
    room      = ~bf_ff & ~ov_ff;
    byte_end  = (st_ff == ssx_pkg::S_RX) & scl_fall & (cnt_ff == ssx_pkg::RX_LAST);
  end

  // Address decision at the 8th falling edge
  always_comb begin
    hit       = 1'h0;
    go_rd     = 1'h0;
    set_ua    = 1'h0;
    hit10_set = 1'h0;
    is_data   = 1'h0;
    nxt_ph    = ph_ff;
    if (slave_on) begin
      unique case (ph_ff)
        ssx_pkg::PH_DATA: begin
          hit     = 1'h1;
          is_data = 1'h1;
        end
        ssx_pkg::PH_A1: begin
          if (!ten && m7) begin
            hit    = 1'h1;
            go_rd  = sr_ff[0];
            nxt_ph = ssx_pkg::PH_DATA;
          end else if (ten && hi_ok && !sr_ff[0]) begin // RL1
            hit    = 1'h1;
            set_ua = 1'h1;
            nxt_ph = ssx_pkg::PH_A2;
          end else if (ten && hi_ok && hit10_ff) begin // RL5
            hit    = 1'h1;
            go_rd  = 1'h1;
            nxt_ph = ssx_pkg::PH_DATA;
          end
        end
        ssx_pkg::PH_A2: begin
          if (m10lo) begin
            hit       = 1'h1;
            set_ua    = 1'h1;
            hit10_set = 1'h1;
            nxt_ph    = ssx_pkg::PH_DATA;
          end
        end
        ssx_pkg::PH_SKIP: begin
        end
      endcase
    end
    if (!hit) nxt_ph = ssx_pkg::PH_SKIP;
    load = byte_end & hit & room; // RL23
  end

  // Bus sequence
  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff  <= ssx_pkg::S_IDLE;
      ph_ff  <= ssx_pkg::PH_SKIP;
      cnt_ff <= ssx_pkg::CNT_RST;
    end else if (!PORT_EN) begin
      st_ff <= ssx_pkg::S_IDLE;
      ph_ff <= ssx_pkg::PH_SKIP;
    end else if (start_det) begin
      st_ff  <= ssx_pkg::S_RX;
      ph_ff  <= ssx_pkg::PH_A1;
      cnt_ff <= ssx_pkg::CNT_RST;
    end else if (stop_det) begin
      st_ff <= ssx_pkg::S_IDLE;
    end else begin
      unique case (st_ff)
        ssx_pkg::S_IDLE: begin
        end
        ssx_pkg::S_RX: begin
          if (scl_rise) cnt_ff <= cnt_ff + ssx_pkg::CNT_ONE;
          if (byte_end) begin
            st_ff <= (hit | fwm) ? ssx_pkg::S_ACK : ssx_pkg::S_IDLE;
            ph_ff <= nxt_ph;
          end
        end
        ssx_pkg::S_ACK: begin
          if (scl_fall) begin
            st_ff  <= (rw_ff & slave_on) ? ssx_pkg::S_TX : ssx_pkg::S_RX;
            cnt_ff <= ssx_pkg::CNT_RST;
          end
        end
        ssx_pkg::S_TX: begin
          if (scl_fall) begin
            cnt_ff <= cnt_ff + ssx_pkg::CNT_ONE;
            if (cnt_ff == ssx_pkg::TX_LAST) st_ff <= ssx_pkg::S_MACK; // RL14
          end
        end
        ssx_pkg::S_MACK: begin
          if (scl_fall) begin
            st_ff  <= nack_ff ? ssx_pkg::S_IDLE : ssx_pkg::S_TX; // RL14
            cnt_ff <= ssx_pkg::CNT_RST;
          end
        end
        default: st_ff <= ssx_pkg::S_IDLE;
      endcase
    end
  end

  // Shift paths and buffer
  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sr_ff   <= ssx_pkg::BYTE_RST;
      tx_ff   <= ssx_pkg::BYTE_RST;
      buf_ff  <= ssx_pkg::BYTE_RST;
      ack_ff  <= 1'h0;
      nack_ff <= 1'h1;
    end else begin
      if (st_ff == ssx_pkg::S_RX && scl_rise) sr_ff <= {sr_ff[6:0], sda_s};
      if (BUF_WR) tx_ff <= BUF_WDATA;
      else if (st_ff == ssx_pkg::S_TX && scl_fall) tx_ff <= {tx_ff[6:0], 1'h0};
      if (load) buf_ff <= sr_ff;        // RL9
      else if (BUF_WR) buf_ff <= BUF_WDATA;
      if (byte_end) ack_ff <= hit & room; // RL23
      if (st_ff == ssx_pkg::S_MACK && scl_rise) nack_ff <= sda_s;
    end
  end

  // Status flags: hardware set wins over software clear
  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bf_ff    <= 1'h0;
      ov_ff    <= 1'h0;
      ua_ff    <= 1'h0;
      da_ff    <= 1'h0;
      rw_ff    <= 1'h0;
      hit10_ff <= 1'h0;
    end else begin
      if (load || (BUF_WR && rw_ff)) bf_ff <= 1'h1;                       // RL2 RL5 RL12
      else if (BUF_RD) bf_ff <= 1'h0;                                     // RL4
      else if (st_ff == ssx_pkg::S_TX && scl_fall && cnt_ff == ssx_pkg::TX_LAST) bf_ff <= 1'h0; // RL13
      if (byte_end && hit && bf_ff && !rw_ff) ov_ff <= 1'h1;             // RL9
      else if (OV_CLR) ov_ff <= 1'h0;
      if (byte_end && set_ua) ua_ff <= 1'h1;                             // RL2
      else if (ADDR_WR && !ld_mask) ua_ff <= 1'h0;                       // RL3
      if (byte_end && hit) da_ff <= is_data;                             // RL10
      if (start_det || stop_det || !PORT_EN) rw_ff <= 1'h0;
      else if (byte_end && hit && !is_data) rw_ff <= go_rd;              // RL11
      if (stop_det || !PORT_EN) hit10_ff <= 1'h0;
      else if (byte_end && hit10_set) hit10_ff <= 1'h1;
    end
  end

  // Interrupt, release bit, start/stop seen
  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_ff <= 1'h0;
      ckp_ff <= ssx_pkg::CKP_RST;
      s_ff   <= 1'h0;
      p_ff   <= 1'h0;
    end else begin
      // Ninth fall of every byte, transmit included
      if (PORT_EN && scl_fall && (st_ff == ssx_pkg::S_ACK || st_ff == ssx_pkg::S_MACK)) irq_ff <= 1'h1; // RL10 RL13
      else if (evt_mode && stop_det) irq_ff <= 1'h1;                         // RL20 RL21
      else if (evt_mode && start_det) irq_ff <= 1'h1;                        // RL20
      else if (IRQ_CLR) irq_ff <= 1'h0;
      // Hardware clear wins so a release never skips a stretch
      if (PORT_EN && scl_fall && ((st_ff == ssx_pkg::S_ACK && rw_ff) ||
          (st_ff == ssx_pkg::S_MACK && !nack_ff))) ckp_ff <= 1'h0;          // RL5 RL11 RL14
      else if (CKP_SET) ckp_ff <= 1'h1;                                      // RL12
      if (!PORT_EN) begin
        s_ff <= 1'h0;                                                        // RL17
        p_ff <= 1'h0;
      end else if (start_det) begin
        s_ff <= 1'h1;
        p_ff <= 1'h0;
      end else if (stop_det) begin
        s_ff <= 1'h0;
        p_ff <= 1'h1;
      end
    end
  end

  // Address and mask share one location
  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      addr_ff         <= ssx_pkg::ADDR_RST;
      mask_ff         <= ssx_pkg::MASK_RST; // RL8
      mask_touched_ff <= 1'h0;
    end else if (ADDR_WR) begin
      if (ld_mask) begin
        mask_ff         <= ADDR_WDATA;      // RL6
        mask_touched_ff <= 1'h1;
      end else begin
        addr_ff <= ADDR_WDATA;
      end
    end
  end

  // Stretch only once the line is seen low
  always_comb begin
    // Address stretch waits until the ack pulse is over
    nxt_hold = slave_on & ((ua_ff & (st_ff != ssx_pkg::S_ACK)) | ~ckp_ff) & (hold_ff | ~scl_s); // RL16 RL25
    sda_drv  = PORT_EN & (((st_ff == ssx_pkg::S_ACK) & ack_ff) | ((st_ff == ssx_pkg::S_TX) & ~tx_ff[7]));
  end

  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      hold_ff    <= 1'h0;
      pin_lo_ff  <= 1'h0;
      SCL_OE_B   <= 1'h1;
      SDA_OE_B   <= 1'h1;
      ADDR_RDATA <= ssx_pkg::ADDR_RST;
    end else begin
      hold_ff    <= nxt_hold;
      pin_lo_ff  <= 1'h0;
      SCL_OE_B   <= SCL_DIR & ~nxt_hold;   // RL19
      SDA_OE_B   <= SDA_DIR & ~sda_drv;    // RL19
      ADDR_RDATA <= ld_mask ? mask_ff : addr_ff;
    end
  end

  always_comb begin
    SCL_O         = pin_lo_ff;
    SDA_O         = pin_lo_ff;
    BUF_RDATA     = buf_ff;
    IRQ_FLAG      = irq_ff;
    BUF_FULL      = bf_ff;
    OVERFLOW      = ov_ff;
    UPDATE_ADDR   = ua_ff;
    CLK_RELEASE   = ckp_ff;
    DATA_NOT_ADDR = da_ff;
    READ_DIR      = rw_ff;
    START_SEEN    = s_ff;
    STOP_SEEN     = p_ff;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_ff);

  property p_ua_stretch;
    (slave_on && ua_ff && st_ff != ssx_pkg::S_ACK && !scl_s) [*2] |=> !SCL_OE_B;
  endproperty
  a_ua_stretch: assert property (p_ua_stretch) else $error("clock not held for address update"); // RL2
  property p_ua_clear;
    ADDR_WR && !ld_mask && !(byte_end && set_ua) |=> !UPDATE_ADDR;
  endproperty
  a_ua_clear: assert property (p_ua_clear) else $error("update flag not cleared"); // RL3
  property p_bf_read;
    BUF_RD && !load && !(BUF_WR && rw_ff) |=> !BUF_FULL;
  endproperty
  a_bf_read: assert property (p_bf_read) else $error("buffer full not cleared by read"); // RL4
  property p_rd_stretch;
    PORT_EN && st_ff == ssx_pkg::S_ACK && scl_fall && rw_ff && slave_on |=> !ckp_ff && st_ff == ssx_pkg::S_TX;
  endproperty
  a_rd_stretch: assert property (p_rd_stretch) else $error("read address did not stretch"); // RL11
  property p_mask_mode;
    ADDR_WR && !ld_mask |=> $stable(mask_ff);
  endproperty
  a_mask_mode: assert property (p_mask_mode) else $error("mask written outside mask mode"); // RL6
  property p_mask_rst;
    !mask_touched_ff |-> mask_ff == ssx_pkg::MASK_RST;
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("mask not all ones"); // RL8
  property p_mask_ign;
    byte_end && slave_on && !ten && ph_ff == ssx_pkg::PH_A1 && !start_det && !stop_det &&
      ((sr_ff ^ addr_ff) & {mask_ff[7:1], 1'h0}) == ssx_pkg::BYTE_RST |=> st_ff == ssx_pkg::S_ACK;
  endproperty
  a_mask_ign: assert property (p_mask_ign) else $error("masked address not matched"); // RL7
  property p_tx_eighth;
    PORT_EN && st_ff == ssx_pkg::S_TX && scl_fall && cnt_ff == ssx_pkg::TX_LAST && !BUF_WR
      |=> !BUF_FULL && st_ff == ssx_pkg::S_MACK ##1 SDA_OE_B == $past(SDA_DIR);
  endproperty
  a_tx_eighth: assert property (p_tx_eighth) else $error("eighth fall handling wrong"); // RL13
  property p_nack_end;
    PORT_EN && st_ff == ssx_pkg::S_MACK && scl_fall && nack_ff |=> st_ff == ssx_pkg::S_IDLE;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("nack did not end transfer"); // RL14
  property p_irq_ninth;
    PORT_EN && (st_ff == ssx_pkg::S_ACK || st_ff == ssx_pkg::S_MACK) && scl_fall |=> IRQ_FLAG;
  endproperty
  a_irq_ninth: assert property (p_irq_ninth) else $error("no irq at ninth fall"); // RL10
  property p_sp_clear;
    !PORT_EN |=> !START_SEEN && !STOP_SEEN;
  endproperty
  a_sp_clear: assert property (p_sp_clear) else $error("start/stop seen not cleared"); // RL17
  property p_evt_irq;
    evt_mode && (start_det || stop_det) |=> IRQ_FLAG;
  endproperty
  a_evt_irq: assert property (p_evt_irq) else $error("no irq on start or stop"); // RL20
  property p_no_ack;
    byte_end && hit && bf_ff |=> !ack_ff && buf_ff == $past(buf_ff);
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("acked or loaded while full"); // RL23

  c_ten_addr: cover property (byte_end && hit10_set);
  c_tx_nack: cover property (st_ff == ssx_pkg::S_MACK && scl_fall && nack_ff);
  c_overflow: cover property ($rose(ov_ff));
  c_fwm_start: cover property (fwm && start_det);
endmodule
`default_nettype wire

//--- bench/ssx_bus_master.sv
/*
  Behavioural two-wire bus master facing the slave port.
  Assumes the bench ANDs m_scl/m_sda with the slave's drives (pull-ups).
*/
`timescale 1ns/1ps
`default_nettype none
module ssx_bus_master (
  input  wire logic scl,
  input  wire logic sda,
  output var  logic m_scl,
  output var  logic m_sda
);
  localparam int HALF = 160;
  localparam int Q    = 80;

  // Outputs only release (1) or pull low (0)
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end

  // Honour stretching, but never wait forever
  task automatic up();
    m_scl = 1'b1;
    for (int i = 0; i < 4000 && scl !== 1'b1; i++) #10;
    #HALF;
  endtask

  task automatic bit_io(input logic b, output logic s);
    #Q;
    m_sda = b;
    #Q;
    up();
    s = sda;
    m_scl = 1'b0;
  endtask

  // Only called from idle, after a stop, or as a repeated start
  task automatic start_c();
    #Q;
    m_sda = 1'b1;
    #Q;
    up();
    m_sda = 1'b0;
    #HALF;
    m_scl = 1'b0;
  endtask

  task automatic stop_c();
    #Q;
    m_sda = 1'b0;
    #Q;
    up();
    m_sda = 1'b1;
    #(2*HALF);
  endtask

  // A one read back low means another master won: let go of both lines
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    logic lost;
    lost = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!lost) bit_io(b[i], s);
      if (b[i] && !s) lost = 1'b1;
    end
    if (lost) begin
      m_sda = 1'b1;
      m_scl = 1'b1;
      ack = 1'b0;
    end else begin
      bit_io(1'b1, s);
      ack = ~s;
    end
    #(2*HALF);
  endtask

  // Ack asks for more; nack ends the read
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~ack, s);
    #(2*HALF);
  endtask
endmodule
`default_nettype wire

//--- bench/tb_ssx_slave.sv
/*
  Self-checking bench of the two-wire slave port.
  Assumes ssx_bus_master on the lines; assertions live in the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_ssx_slave;
  logic       clk, rst_b, scl_dir, sda_dir, port_en, ack, m_scl, m_sda;
  logic       buf_wr, buf_rd, addr_wr, ckp_set, irq_clr, ov_clr;
  logic       scl_o, scl_oe_b, sda_o, sda_oe_b, irq, bf, ov, ua, clock_release_bit;
  logic       dna, rdir, sts, sps;
  logic [3:0] mode;
  logic [7:0] buf_wdata, addr_wdata, rb, buf_rdata, addr_rdata;
  wire logic  scl, sda;
  int         fail_count, checks, cyc;

  // Small skew keeps pin changes off the sampling edge
  assign #3 scl = m_scl & (scl_oe_b | scl_o);
  assign #3 sda = m_sda & (sda_oe_b | sda_o);

  ssx_bus_master mst (.scl(scl), .sda(sda), .m_scl(m_scl), .m_sda(m_sda));

  ssx_slave dut_u (
    .REF_CLK(clk), .RST_B(rst_b), .SCL_I(scl), .SDA_I(sda),
    .SCL_DIR(scl_dir), .SDA_DIR(sda_dir), .PORT_EN(port_en), .MODE(mode),
    .BUF_WR(buf_wr), .BUF_WDATA(buf_wdata), .BUF_RD(buf_rd), .ADDR_WR(addr_wr),
    .ADDR_WDATA(addr_wdata), .CKP_SET(ckp_set), .IRQ_CLR(irq_clr), .OV_CLR(ov_clr),
    .SCL_O(scl_o), .SCL_OE_B(scl_oe_b), .SDA_O(sda_o), .SDA_OE_B(sda_oe_b),
    .BUF_RDATA(buf_rdata), .ADDR_RDATA(addr_rdata), .IRQ_FLAG(irq), .BUF_FULL(bf),
    .OVERFLOW(ov), .UPDATE_ADDR(ua), .CLK_RELEASE(clock_release_bit), .DATA_NOT_ADDR(dna),
    .READ_DIR(rdir), .START_SEEN(sts), .STOP_SEEN(sps));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim();
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Strobe kinds: 0 buf wr, 1 buf rd, 2 addr wr, 3 release, 4 irq clr, 5 ov clr
  task automatic cpu(input int k, input logic [7:0] d);
    @(posedge clk);
    buf_wr     <= (k == 0);
    buf_rd     <= (k == 1);
    addr_wr    <= (k == 2);
    ckp_set    <= (k == 3);
    irq_clr    <= (k == 4);
    ov_clr     <= (k == 5);
    buf_wdata  <= d;
    addr_wdata <= d;
    @(posedge clk);
    {buf_wr, buf_rd, addr_wr, ckp_set, irq_clr, ov_clr} <= 6'h00;
    repeat (3) @(posedge clk);
  endtask

  task automatic set_mode(input logic [3:0] m);
    @(posedge clk);
    mode <= m;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset();
    chk({2'h0, bf, irq, ov, ua, clock_release_bit, sts}, 8'h00);
    chk({6'h00, scl_o, sda_o}, 8'h00);
    set_mode(ssx_pkg::MODE_LDMSK);
    chk(addr_rdata, 8'hFF);
    cpu(2, 8'hF1);
    chk(addr_rdata, 8'hF1);
    set_mode(ssx_pkg::MODE_S7);
    chk(addr_rdata, 8'h00);
  endtask

  // Mask F1 ignores address bits 3..1
  task automatic t_wr7();
    cpu(2, 8'hA0);
    cpu(3, 8'h00);
    mst.start_c();
    mst.wr_byte(8'hA6, ack);
    chk(8'(ack), 8'h01);
    chk(buf_rdata, 8'hA6);
    chk({4'h0, bf, irq, dna, rdir}, 8'h0C);
    chk(8'(sts), 8'h01);
    cpu(1, 8'h00);
    chk(8'(bf), 8'h00);
    cpu(4, 8'h00);
    mst.wr_byte(8'h3C, ack);
    chk(8'(ack), 8'h01);
    chk({4'h0, bf, irq, dna, rdir}, 8'h0E);
    cpu(4, 8'h00);
    mst.wr_byte(8'h55, ack);
    chk({4'h0, ack, ov, irq, bf}, 8'h07);
    chk(buf_rdata, 8'h3C);
    mst.stop_c();
    chk({6'h00, sts, sps}, 8'h01);
    cpu(1, 8'h00);
    cpu(5, 8'h00);
    cpu(4, 8'h00);
    mst.start_c();
    mst.wr_byte(8'hB0, ack);
    chk(8'(ack), 8'h00);
    mst.stop_c();
  endtask

  task automatic t_ten();
    set_mode(ssx_pkg::MODE_S10);
    cpu(2, 8'hF2);
    cpu(3, 8'h00);
    mst.start_c();
    mst.wr_byte(8'hF2, ack);
    chk({4'h0, ack, ua, bf, irq}, 8'h0F);
    chk(8'(scl_oe_b), 8'h00);
    cpu(1, 8'h00);
    cpu(4, 8'h00);
    cpu(2, 8'h34);
    chk({6'h00, ua, scl_oe_b}, 8'h01);
    mst.wr_byte(8'h34, ack);
    chk({5'h00, ack, ua, bf}, 8'h07);
    cpu(2, 8'hF2);
    chk(8'(ua), 8'h00);
    cpu(1, 8'h00);
    cpu(4, 8'h00);
    mst.start_c();
    mst.wr_byte(8'hF3, ack);
    chk({4'h0, ack, bf, clock_release_bit, rdir}, 8'h0D);
    chk(8'(scl_oe_b), 8'h00);
    cpu(1, 8'h00);
    cpu(4, 8'h00);
    cpu(0, 8'hC5);
    chk(8'(bf), 8'h01);
    cpu(3, 8'h00);
    chk(8'(clock_release_bit), 8'h01);
    mst.rd_byte(1'b1, rb);
    chk(rb, 8'hC5);
    chk({6'h00, bf, irq}, 8'h01);
    chk({6'h00, clock_release_bit, scl_oe_b}, 8'h00);
    cpu(4, 8'h00);
    cpu(0, 8'h5A);
    cpu(3, 8'h00);
    mst.rd_byte(1'b0, rb);
    chk(rb, 8'h5A);
    mst.stop_c();
  endtask

  task automatic t_evt();
    set_mode(ssx_pkg::MODE_FWM);
    cpu(4, 8'h00);
    mst.start_c();
    chk({6'h00, irq, sts}, 8'h03);
    cpu(4, 8'h00);
    mst.stop_c();
    chk({6'h00, irq, sps}, 8'h03);
    @(posedge clk);
    sda_dir <= 1'b0;
    repeat (4) @(posedge clk);
    chk(8'(sda_oe_b), 8'h00);
    sda_dir <= 1'b1;
    port_en <= 1'b0;
    repeat (4) @(posedge clk);
    chk({6'h00, sts, sps}, 8'h00);
    port_en <= 1'b1;
    // Slave modes with start/stop events, both address widths
    for (int k = 0; k < 2; k++) begin
      set_mode(k ? ssx_pkg::MODE_S10I : ssx_pkg::MODE_S7I);
      cpu(4, 8'h00);
      mst.start_c();
      chk({6'h00, irq, sts}, 8'h03);
      cpu(4, 8'h00);
      mst.stop_c();
      chk({6'h00, irq, sps}, 8'h03);
    end
  endtask

  // A hung handshake ends here as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    {rst_b, buf_wr, buf_rd, addr_wr, ckp_set, irq_clr, ov_clr} = 7'h00;
    {scl_dir, sda_dir, port_en} = 3'h7;
    mode = ssx_pkg::MODE_S7;
    buf_wdata = 8'h00;
    addr_wdata = 8'h00;
    fail_count = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_wr7();
    t_ten();
    t_evt();
    end_sim();
  end
endmodule
`default_nettype wire
